//--- hw/ur_uart.sv
// Full-duplex serial port with receive FIFO and reload-timer baud generator.
// Assumes one clock; serial_in_pin and usb_domain_clock arrive asynchronously.
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/1ps

// Notes on behaviour
// - Frame is low start, data LSB first, optional extra/parity, high stops.
// - Two-bit length field picks 5, 6, 7 or 8 data bits.
// - Parity type field picks odd, even, mark or space.
// - Parity, when on, takes the extra bit position.
// - Stop length bit picks one or two stop bits.
// - Two stop bits never apply to 5-bit characters.
// - Writing the data buffer loads the shifter and starts sending.
// - Transmit-done sets at the start of the stop bit time.
// - Extra bit on and parity off sends the transmit extra bit.
// - Parity on makes the transmitter append the computed parity bit.
// - Receiver runs only with receive enable set; FIFO stays readable.
// - A good frame is stored only if FIFO not full and stops high.
// - A byte with high stops arriving with FIFO full is lost and sets overrun.
// - A frame whose stop samples low is dropped.
// - Storing sets receive-done; in multiprocessor mode only if extra bit is one.
// - Data buffer reads return oldest byte and free its entry.
// - Received extra bit shows head extra bit if extra bit on and parity off, else head stop bit.
// - Parity on makes the receiver flag a parity mismatch.
// - Parity error stays set until software clears it.
// - Receive-done cannot be cleared while bytes remain in the FIFO.
// - Timer counts up from reload value and reloads on overflow.
// - Port runs only with baud generator on; clock is system or USB.
module ur_uart
  import ur_pkg::*;
#(
  parameter int FIFO_DEPTH = UR_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [UR_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Serial pins and alternate baud clock
  input wire logic serial_in_pin,
  input wire logic usb_domain_clock,
  output logic serial_out_pin
);
  localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
  localparam int CW = $clog2(FIFO_DEPTH + 1);
  localparam logic [PW-1:0] LAST_PTR = PW'(FIFO_DEPTH - 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(FIFO_DEPTH);

  logic [7:0] baud_gen_control;
  logic [7:0] frame_format_mode;
  logic [7:0] baud_reload_high;
  logic [7:0] baud_reload_low;
  logic receive_overrun_flag;
  logic parity_error_flag;
  logic receive_enable_bit;
  logic transmit_extra_bit;
  logic transmit_done_flag;
  logic receive_done_flag;

  function automatic logic hit(input logic [7:0] idx, input logic [7:0] reg_idx);
    hit = idx == reg_idx;
  endfunction

  function automatic logic par_bit(input logic [7:0] d, input logic [1:0] dl,
                                   input logic [1:0] pt);
    logic x;
    x = ^(d & (8'hff >> ~dl));
    unique case (pt)
      UR_PT_ODD: par_bit = ~x;
      UR_PT_EVEN: par_bit = x;
      UR_PT_MARK: par_bit = 1'b1;
      UR_PT_SPACE: par_bit = 1'b0;
    endcase
  endfunction

  function automatic logic [PW-1:0] nxt(input logic [PW-1:0] p);
    nxt = (p == LAST_PTR) ? '0 : p + PW'(1);
  endfunction

  // Format fields
  logic mce, pe, xbe, sbl, xtra_on, two_stop;
  logic [1:0] pt, dl;
  logic [2:0] last_bit;
  assign mce = frame_format_mode[FM_MCE];
  assign pt = frame_format_mode[FM_PT+:2];
  assign pe = frame_format_mode[FM_PE];
  assign dl = frame_format_mode[FM_DL+:2];
  assign xbe = frame_format_mode[FM_XBE];
  assign sbl = frame_format_mode[FM_SBL];
  assign xtra_on = pe || xbe;
  assign two_stop = sbl && (dl != UR_DL_5);
  assign last_bit = {1'b1, dl};

  // Bus access: answered one cycle after the request is seen
  logic [7:0] idx;
  logic bus_wr, bus_rd, wr_data, wr_scon;
  assign idx = avs_address[UR_ADDR_W-1:UR_IDX_LSB];
  assign bus_wr = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign bus_rd = avs_read && !avs_waitrequest;
  assign wr_data = bus_wr && hit(idx, UR_IDX_DATA);
  assign wr_scon = bus_wr && hit(idx, UR_IDX_SCON);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end
  end

  // Receive FIFO
  logic [8:0] fifo_mem [FIFO_DEPTH];
  logic [PW-1:0] wr_ptr, rd_ptr;
  logic [CW-1:0] fifo_cnt;
  logic fifo_full, fifo_push, fifo_pop;
  logic [8:0] fifo_din;
  assign fifo_full = fifo_cnt == FULL_CNT;
  assign fifo_pop = bus_rd && hit(idx, UR_IDX_DATA) && (fifo_cnt != '0);

  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = UR_RST_ZERO;
    if (hit(idx, UR_IDX_BAUD_CTL)) begin
      rd_mux = baud_gen_control;
    end else if (hit(idx, UR_IDX_RLD_HI)) begin
      rd_mux = baud_reload_high;
    end else if (hit(idx, UR_IDX_RLD_LO)) begin
      rd_mux = baud_reload_low;
    end else if (hit(idx, UR_IDX_FMT)) begin
      rd_mux = frame_format_mode;
    end else if (hit(idx, UR_IDX_SCON)) begin
      rd_mux = UR_RST_SCON;
      rd_mux[SC_OVR] = receive_overrun_flag;
      rd_mux[SC_PERR] = parity_error_flag;
      rd_mux[SC_REN] = receive_enable_bit;
      rd_mux[SC_TBX] = transmit_extra_bit;
      rd_mux[SC_TBX-1] = fifo_mem[rd_ptr][8];
      rd_mux[SC_TI] = transmit_done_flag;
      rd_mux[SC_RI] = receive_done_flag;
    end else if (hit(idx, UR_IDX_DATA)) begin
      rd_mux = fifo_mem[rd_ptr][7:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= {24'h00_0000, rd_mux};
    end
  end

  // Configuration registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      baud_gen_control <= UR_RST_ZERO;
      baud_reload_high <= UR_RST_ZERO;
      baud_reload_low <= UR_RST_ZERO;
      frame_format_mode <= UR_RST_FMT;
    end else if (bus_wr) begin
      if (hit(idx, UR_IDX_BAUD_CTL)) baud_gen_control <= avs_writedata[7:0];
      if (hit(idx, UR_IDX_RLD_HI)) baud_reload_high <= avs_writedata[7:0];
      if (hit(idx, UR_IDX_RLD_LO)) baud_reload_low <= avs_writedata[7:0];
      if (hit(idx, UR_IDX_FMT)) frame_format_mode <= avs_writedata[7:0];
    end
  end

  // Baud generator; the USB clock is only sampled, so it must be slower
  // than half of sys_clk for its edges to be seen.
  logic usb_s1, usb_s2, usb_s3;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      usb_s1 <= 1'b0;
      usb_s2 <= 1'b0;
      usb_s3 <= 1'b0;
    end else begin
      usb_s1 <= usb_domain_clock;
      usb_s2 <= usb_s1;
      usb_s3 <= usb_s2;
    end
  end

  logic brg_on, src_tick, ps_done, half_tick;
  logic [5:0] ps_cnt, ps_m1;
  logic [15:0] brg_cnt;
  assign brg_on = baud_gen_control[BC_EN];
  assign src_tick = baud_gen_control[BC_CLK] ? (usb_s2 && !usb_s3) : 1'b1;
  always_comb begin
    unique case (baud_gen_control[BC_PS+:2])
      2'h0: ps_m1 = UR_PS_M1_0;
      2'h1: ps_m1 = UR_PS_M1_1;
      2'h2: ps_m1 = UR_PS_M1_2;
      2'h3: ps_m1 = UR_PS_M1_3;
    endcase
  end
  assign ps_done = src_tick && (ps_cnt >= ps_m1);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ps_cnt <= '0;
      brg_cnt <= '0;
      half_tick <= 1'b0;
    end else if (!brg_on) begin
      ps_cnt <= '0;
      brg_cnt <= {baud_reload_high, baud_reload_low};
      half_tick <= 1'b0;
    end else begin
      half_tick <= 1'b0;
      if (src_tick) ps_cnt <= ps_done ? '0 : ps_cnt + 6'h01;
      if (ps_done) begin
        // Overflow gives twice the bit rate; each bit takes two ticks
        if (brg_cnt == UR_TMR_TOP) begin
          brg_cnt <= {baud_reload_high, baud_reload_low};
          half_tick <= 1'b1;
        end else begin
          brg_cnt <= brg_cnt + 16'h0001;
        end
      end
    end
  end

  // Transmitter; a write while a frame is in flight is ignored
  ur_frame_e tx_st;
  logic tx_ph, tx_xbit, tx_step, tdone_set;
  logic [2:0] tx_cnt;
  logic [7:0] tx_shift;
  assign tx_step = half_tick && tx_ph;
  assign tdone_set = tx_step && (((tx_st == UR_DATA) && (tx_cnt == last_bit)
                     && !xtra_on) || (tx_st == UR_XTRA));

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_st <= UR_IDLE;
      tx_ph <= 1'b0;
      tx_cnt <= '0;
      tx_shift <= UR_RST_ZERO;
      tx_xbit <= 1'b0;
      serial_out_pin <= 1'b1;
    end else if (!brg_on) begin
      tx_st <= UR_IDLE;
      serial_out_pin <= 1'b1;
    end else if (tx_st == UR_IDLE) begin
      if (wr_data) begin
        tx_shift <= avs_writedata[7:0];
        // Parity replaces the extra bit when enabled
        tx_xbit <= pe ? par_bit(avs_writedata[7:0], dl, pt)
                      : transmit_extra_bit;
        tx_st <= UR_START;
        tx_ph <= 1'b0;
        serial_out_pin <= 1'b0;
      end
    end else if (half_tick) begin
      tx_ph <= !tx_ph;
      if (tx_ph) begin
        unique case (tx_st)
          UR_START: begin
            tx_st <= UR_DATA;
            tx_cnt <= '0;
            serial_out_pin <= tx_shift[0];
            tx_shift <= tx_shift >> 1;
          end
          UR_DATA: begin
            if (tx_cnt == last_bit) begin
              tx_st <= xtra_on ? UR_XTRA : UR_STOP1;
              serial_out_pin <= xtra_on ? tx_xbit : 1'b1;
            end else begin
              tx_cnt <= tx_cnt + 3'h1;
              serial_out_pin <= tx_shift[0];
              tx_shift <= tx_shift >> 1;
            end
          end
          UR_XTRA: begin
            tx_st <= UR_STOP1;
            serial_out_pin <= 1'b1;
          end
          UR_STOP1: tx_st <= two_stop ? UR_STOP2 : UR_IDLE;
          UR_STOP2: tx_st <= UR_IDLE;
          default: tx_st <= UR_IDLE;
        endcase
      end
    end
  end

  // Receiver; a tick arrives at an arbitrary phase, so samples land
  // somewhere in the first half of each bit.
  logic rx_s1, rx_s2;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
    end else begin
      rx_s1 <= serial_in_pin;
      rx_s2 <= rx_s1;
    end
  end

  ur_frame_e rx_st;
  logic rx_ph, rx_xbit, rx_stop_ok, rx_end;
  logic [2:0] rx_cnt;
  logic [7:0] rx_shift, rx_data;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_st <= UR_IDLE;
      rx_ph <= 1'b0;
      rx_cnt <= '0;
      rx_shift <= UR_RST_ZERO;
      rx_xbit <= 1'b0;
      rx_stop_ok <= 1'b0;
      rx_end <= 1'b0;
    end else begin
      rx_end <= 1'b0;
      if (!receive_enable_bit || !brg_on) begin
        rx_st <= UR_IDLE;
      end else if (rx_st == UR_IDLE) begin
        if (!rx_s2) begin
          rx_st <= UR_START;
          rx_ph <= 1'b0;
        end
      end else if (half_tick) begin
        rx_ph <= !rx_ph;
        if (!rx_ph) begin
          unique case (rx_st)
            UR_START: begin
              rx_st <= rx_s2 ? UR_IDLE : UR_DATA;
              rx_cnt <= '0;
            end
            UR_DATA: begin
              rx_shift <= {rx_s2, rx_shift[7:1]};
              if (rx_cnt == last_bit) rx_st <= xtra_on ? UR_XTRA : UR_STOP1;
              else rx_cnt <= rx_cnt + 3'h1;
            end
            UR_XTRA: begin
              rx_xbit <= rx_s2;
              rx_st <= UR_STOP1;
            end
            UR_STOP1: begin
              rx_stop_ok <= rx_s2;
              rx_st <= two_stop ? UR_STOP2 : UR_IDLE;
              rx_end <= !two_stop;
            end
            UR_STOP2: begin
              rx_stop_ok <= rx_stop_ok && rx_s2;
              rx_st <= UR_IDLE;
              rx_end <= 1'b1;
            end
            default: rx_st <= UR_IDLE;
          endcase
        end
      end
    end
  end

  // Short characters arrive in the top bits of the shifter
  assign rx_data = rx_shift >> ~dl;
  assign fifo_push = rx_end && rx_stop_ok && !fifo_full;
  assign fifo_din = {((xbe && !pe) ? rx_xbit : rx_stop_ok), rx_data};

  // Cleared so the data buffer and received extra bit read defined values before any byte
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < FIFO_DEPTH; i++) begin
        fifo_mem[i] <= '0;
      end
    end else if (fifo_push) begin
      fifo_mem[wr_ptr] <= fifo_din;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fifo_cnt <= '0;
    end else begin
      if (fifo_push) wr_ptr <= nxt(wr_ptr);
      if (fifo_pop) rd_ptr <= nxt(rd_ptr);
      fifo_cnt <= fifo_cnt + CW'(fifo_push) - CW'(fifo_pop);
    end
  end

  // Status flags; a hardware set wins over a software write
  logic rdone_set, ovr_set, perr_set;
  assign rdone_set = fifo_push && (!mce || rx_xbit);
  assign ovr_set = rx_end && rx_stop_ok && fifo_full;
  assign perr_set = rx_end && pe && (rx_xbit != par_bit(rx_data, dl, pt));

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      receive_enable_bit <= 1'b0;
      transmit_extra_bit <= 1'b0;
    end else if (wr_scon) begin
      receive_enable_bit <= avs_writedata[SC_REN];
      transmit_extra_bit <= avs_writedata[SC_TBX];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      transmit_done_flag <= 1'b0;
      receive_done_flag <= 1'b0;
      receive_overrun_flag <= 1'b0;
      parity_error_flag <= 1'b0;
    end else begin
      if (tdone_set) transmit_done_flag <= 1'b1;
      else if (wr_scon) transmit_done_flag <= avs_writedata[SC_TI];
      if (rdone_set) receive_done_flag <= 1'b1;
      else if (wr_scon && (avs_writedata[SC_RI] || fifo_cnt == '0))
        receive_done_flag <= avs_writedata[SC_RI];
      if (ovr_set) receive_overrun_flag <= 1'b1;
      else if (wr_scon) receive_overrun_flag <= avs_writedata[SC_OVR];
      if (perr_set) parity_error_flag <= 1'b1;
      else if (wr_scon) parity_error_flag <= avs_writedata[SC_PERR];
    end
  end

  // Checks
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_bus_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_enter_stop;
    (tx_st != UR_STOP1) ##1 (tx_st == UR_STOP1);
  endsequence

  a_bus_one_wait: assert property (s_bus_req |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not after one wait cycle");
  a_tx_start_low: assert property ((tx_st == UR_IDLE) && wr_data && brg_on
    |=> (tx_st == UR_START) && !serial_out_pin)
    else $error("write did not start a frame");
  a_tdone_stop: assert property (s_enter_stop |-> transmit_done_flag && serial_out_pin)
    else $error("transmit done missing at stop bit");
  a_no_stop2_short: assert property ((tx_st == UR_STOP2) |-> (dl != UR_DL_5))
    else $error("second stop bit on 5-bit character");
  a_fifo_bound: assert property (fifo_cnt <= FULL_CNT)
    else $error("receive FIFO count beyond depth");
  a_overrun_set: assert property (rx_end && rx_stop_ok && fifo_full
    |=> receive_overrun_flag && (fifo_cnt <= FULL_CNT))
    else $error("overrun not flagged");
  a_bad_stop_drop: assert property (rx_end && !rx_stop_ok && !fifo_pop
    |=> $stable(fifo_cnt))
    else $error("frame with low stop was stored");
  a_perr_sticky: assert property (parity_error_flag && !wr_scon |=> parity_error_flag)
    else $error("parity error cleared by hardware");
  a_ri_hold: assert property (receive_done_flag && (fifo_cnt != '0) && wr_scon
    |=> receive_done_flag)
    else $error("receive done cleared with bytes pending");
  a_rx_off: assert property (!receive_enable_bit |=> (rx_st == UR_IDLE))
    else $error("receiver active while disabled");
  a_mce_gate: assert property (fifo_push && mce && !rx_xbit && !receive_done_flag
    && !wr_scon |=> !receive_done_flag)
    else $error("receive done set for data byte in multiprocessor mode");
endmodule

//--- include/ur_pkg.sv
// Constants, register map and state types for the serial port.
// Assumes a 32-bit Avalon-MM slave port with one register per word.
package ur_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] UR_IDX_BAUD_CTL = 8'h91;
  localparam logic [7:0] UR_IDX_RLD_HI = 8'h93;
  localparam logic [7:0] UR_IDX_RLD_LO = 8'h94;
  localparam logic [7:0] UR_IDX_SCON = 8'h98;
  localparam logic [7:0] UR_IDX_DATA = 8'h99;
  localparam logic [7:0] UR_IDX_FMT = 8'h9a;
  localparam int UR_ADDR_W = 10;
  localparam int UR_IDX_LSB = 2;
  // Reset values
  localparam logic [7:0] UR_RST_ZERO = 8'h00;
  localparam logic [7:0] UR_RST_SCON = 8'h20;
  localparam logic [7:0] UR_RST_FMT = 8'h0c;
  // serial_control_status bits
  localparam int SC_OVR = 7;
  localparam int SC_PERR = 6;
  localparam int SC_REN = 4;
  localparam int SC_TBX = 3;
  localparam int SC_TI = 1;
  localparam int SC_RI = 0;
  // frame_format_mode bits
  localparam int FM_MCE = 7;
  localparam int FM_PT = 5;
  localparam int FM_PE = 4;
  localparam int FM_DL = 2;
  localparam int FM_XBE = 1;
  localparam int FM_SBL = 0;
  // baud_gen_control bits
  localparam int BC_CLK = 7;
  localparam int BC_EN = 6;
  localparam int BC_PS = 0;
  // Codes
  localparam logic [1:0] UR_DL_5 = 2'h0;
  localparam logic [1:0] UR_PT_ODD = 2'h0;
  localparam logic [1:0] UR_PT_EVEN = 2'h1;
  localparam logic [1:0] UR_PT_MARK = 2'h2;
  localparam logic [1:0] UR_PT_SPACE = 2'h3;
  // Prescale divisors minus one, by select code
  localparam logic [5:0] UR_PS_M1_0 = 6'h0b;
  localparam logic [5:0] UR_PS_M1_1 = 6'h03;
  localparam logic [5:0] UR_PS_M1_2 = 6'h2f;
  localparam logic [5:0] UR_PS_M1_3 = 6'h00;
  localparam logic [15:0] UR_TMR_TOP = 16'hffff;
  localparam int UR_FIFO_DEPTH = 3;
  typedef enum logic [2:0] {
    UR_IDLE, UR_START, UR_DATA, UR_XTRA, UR_STOP1, UR_STOP2
  } ur_frame_e;
endpackage

//--- verif/ur_remote_node.sv
// Behavioural far-end serial node: sends frames into the port and samples frames out of it.
// Assumes the bench sets bitlen to the port's bit time in sys_clk cycles.
`timescale 1ns/1ps
module ur_remote_node (
  // Clock
  input wire logic clk,
  // Serial lines
  output logic line_to_dut,
  input wire logic line_from_dut
);
  int bitlen = 16;

  initial line_to_dut = 1'b1;

  // Low start, given bits LSB first, then idle high long enough for the store
  task automatic send(input logic [11:0] v, input int n);
    line_to_dut <= 1'b0;
    repeat (bitlen) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      line_to_dut <= v[i];
      repeat (bitlen) @(posedge clk);
    end
    line_to_dut <= 1'b1;
    repeat (2 * bitlen) @(posedge clk);
  endtask

  // Start bit length varies by half a bit, so sample a quarter bit past its latest end
  task automatic capture(input int n, output logic [11:0] v);
    v = '0;
    @(negedge line_from_dut);
    repeat (bitlen + bitlen / 4) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      v[i] = line_from_dut;
      repeat (bitlen) @(posedge clk);
    end
  endtask
endmodule

//--- verif/tb_uart_with_rx_fifo_and_baud_gen.sv
// Self-checking bench for the serial port: register bus, transmit formats, receive FIFO.
// Assumes the remote node model drives serial_in_pin and samples serial_out_pin.
`timescale 1ns/1ps
module tb_uart_with_rx_fifo_and_baud_gen
  import ur_pkg::*;
;
  logic sys_clk, rst, avs_read, avs_write, avs_waitrequest;
  logic serial_in_pin, serial_out_pin, usb_domain_clock;
  logic [UR_ADDR_W-1:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  int n_errors = 0;
  int cmp_count = 0;
  logic [7:0] r;
  logic [7:0] b [4];
  logic [11:0] got;
  logic [7:0] ridx [7] = '{UR_IDX_BAUD_CTL, UR_IDX_RLD_HI, UR_IDX_RLD_LO, UR_IDX_SCON,
                           UR_IDX_FMT, UR_IDX_DATA, 8'h95};
  logic [7:0] rval [7] = '{UR_RST_ZERO, UR_RST_ZERO, UR_RST_ZERO, UR_RST_SCON,
                           UR_RST_FMT, UR_RST_ZERO, UR_RST_ZERO};
  logic [7:0] bc [5] = '{8'h40, 8'h42, 8'h41, 8'hc3, 8'h43};
  logic [15:0] rl [5] = '{16'hffff, 16'hffff, 16'hfffe, 16'hfffe, 16'hfff8};
  int bl [5] = '{24, 96, 16, 17, 16};

  ur_uart dut_u (
    .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .serial_in_pin(serial_in_pin), .usb_domain_clock(usb_domain_clock),
    .serial_out_pin(serial_out_pin)
  );

  ur_remote_node peer_u (
    .clk(sys_clk), .line_to_dut(serial_in_pin), .line_from_dut(serial_out_pin)
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Odd half period of 21 ns still lets the alternate clock's edges meet sys_clk edges every 105 ns
  initial begin
    usb_domain_clock = 1'b0;
    forever #21 usb_domain_clock = ~usb_domain_clock;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, g, e);
    end
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Entered just after a rising edge; holds the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     input logic [3:0] be, output logic [7:0] q);
    int k;
    k = 0;
    avs_address <= {a, 2'b00};
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= {24'h00_0000, d};
    avs_byteenable <= be;
    do begin
      @(posedge sys_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    q = avs_readdata[7:0];
    if (k >= 50) n_errors++;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] unused;
    bus(1'b1, a, d, 4'h1, unused);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    bus(1'b0, a, 8'h00, 4'h1, q);
  endtask

  // Bits after the start bit, LSB first, with n set to how many the frame carries
  function automatic logic [11:0] exp_frame(input logic [7:0] f, input logic tbx,
                                            input logic [7:0] d, output int n);
    logic [11:0] v;
    logic [7:0] m;
    logic x;
    logic xo;
    int nd;
    nd = int'(f[3:2]) + 5;
    m = 8'hff >> (8 - nd);
    v = {4'h0, d & m};
    x = tbx;
    if (f[FM_PE]) begin
      case (f[6:5])
        UR_PT_ODD: x = ~^(d & m);
        UR_PT_EVEN: x = ^(d & m);
        UR_PT_MARK: x = 1'b1;
        default: x = 1'b0;
      endcase
    end
    xo = f[FM_PE] || f[FM_XBE];
    v[nd] = xo ? x : 1'b1;
    v[nd + 1] = 1'b1;
    v[nd + 2] = 1'b1;
    n = nd + int'(xo) + 1 + int'(f[FM_SBL] && f[3:2] != UR_DL_5);
    return v & (12'hfff >> (12 - n));
  endfunction

  task automatic tx_check(input logic [7:0] f, input logic tbx, input logic [7:0] d);
    logic [11:0] e;
    int n;
    e = exp_frame(f, tbx, d, n);
    wr(UR_IDX_SCON, {4'h1, tbx, 3'b000});
    wr(UR_IDX_FMT, f);
    fork
      peer_u.capture(n, got);
      wr(UR_IDX_DATA, d);
    join
    chk(got, e);
    rd(UR_IDX_SCON, r);
    chk(r[SC_TI], 1'b1);
  endtask

  initial begin
    repeat (60000) @(posedge sys_clk);
    n_errors++;
    end_of_test();
  end

  initial begin
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = '0;
    avs_writedata = '0;
    avs_byteenable = 4'h1;
    void'($urandom(32'hfc12_0041));
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    foreach (ridx[i]) begin
      rd(ridx[i], r);
      chk(r, rval[i]);
    end
    wr(8'h95, 8'h5a);
    rd(8'h95, r);
    chk(r, 8'h00);
    bus(1'b1, UR_IDX_FMT, 8'hff, 4'h0, r);
    rd(UR_IDX_FMT, r);
    chk(r, UR_RST_FMT);
    // Generator off: a data write must not start a frame
    wr(UR_IDX_BAUD_CTL, 8'h03);
    wr(UR_IDX_DATA, 8'h00);
    r = 8'h00;
    repeat (100) begin
      @(posedge sys_clk);
      if (serial_out_pin !== 1'b1) r = 8'h01;
    end
    chk(r, 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr(UR_IDX_RLD_HI, rl[i][15:8]);
      wr(UR_IDX_RLD_LO, rl[i][7:0]);
      wr(UR_IDX_BAUD_CTL, bc[i]);
      peer_u.bitlen = bl[i];
      rd(UR_IDX_RLD_LO, r);
      chk(r, rl[i][7:0]);
      tx_check(8'h0c, 1'b0, 8'($urandom));
    end
    for (int i = 0; i < 32; i++) begin
      tx_check({1'b0, 2'(i >> 3), 1'(i >> 2), 2'(i), 2'($urandom)}, 1'($urandom),
               8'($urandom));
    end
    wr(UR_IDX_FMT, 8'h0c);
    wr(UR_IDX_SCON, 8'h10);
    for (int i = 0; i < 4; i++) begin
      b[i] = 8'($urandom);
      peer_u.send({3'b000, 1'b1, b[i]}, 9);
    end
    rd(UR_IDX_SCON, r);
    chk(r & 8'hc5, 8'h85);
    wr(UR_IDX_SCON, 8'h10);
    rd(UR_IDX_SCON, r);
    chk(r & 8'hc1, 8'h01);
    for (int i = 0; i < 3; i++) begin
      rd(UR_IDX_DATA, r);
      chk(r, b[i]);
    end
    wr(UR_IDX_SCON, 8'h10);
    rd(UR_IDX_SCON, r);
    chk(r & 8'h01, 8'h00);
    peer_u.send({3'b000, 1'b0, 8'h5a}, 9);
    wr(UR_IDX_SCON, 8'h00);
    peer_u.send({3'b000, 1'b1, 8'ha5}, 9);
    rd(UR_IDX_SCON, r);
    chk(r & 8'h81, 8'h00);
    // Empty FIFO shows the stale entry at the read pointer, which has wrapped to slot 0
    rd(UR_IDX_DATA, r);
    chk(r, b[0]);
    wr(UR_IDX_SCON, 8'h10);
    wr(UR_IDX_FMT, 8'h3c);
    peer_u.send({2'b00, 1'b1, ~^b[0], b[0]}, 10);
    peer_u.send({2'b00, 1'b1, ^b[1], b[1]}, 10);
    rd(UR_IDX_SCON, r);
    chk(r & 8'h40, 8'h40);
    rd(UR_IDX_DATA, r);
    chk(r, b[0]);
    rd(UR_IDX_DATA, r);
    chk(r, b[1]);
    wr(UR_IDX_SCON, 8'h10);
    rd(UR_IDX_SCON, r);
    chk(r & 8'h40, 8'h00);
    wr(UR_IDX_FMT, 8'h8e);
    peer_u.send({2'b00, 1'b1, 1'b0, b[2]}, 10);
    rd(UR_IDX_SCON, r);
    chk(r & 8'h05, 8'h00);
    peer_u.send({2'b00, 1'b1, 1'b1, b[3]}, 10);
    rd(UR_IDX_SCON, r);
    chk(r & 8'h05, 8'h01);
    rd(UR_IDX_DATA, r);
    chk(r, b[2]);
    rd(UR_IDX_SCON, r);
    chk(r & 8'h04, 8'h04);
    rd(UR_IDX_DATA, r);
    chk(r, b[3]);
    end_of_test();
  end
endmodule
